//--- hdl/isnz_pkg.sv
package isnz_pkg;

  // Opcode layout
  localparam logic [5:0] OPC_INC_SKIP_NZ = 6'h12;
  localparam int         OPC_MSB         = 15;
  localparam int         OPC_LSB         = 10;
  localparam int         DEST_BIT        = 9;
  localparam int         ACC_BIT         = 8;

  // Data memory addressing
  localparam int         BANK_W          = 4;
  localparam int         ADDR_W          = 12;
  localparam logic [7:0] INDEX_MAX       = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK  = 4'hF;

  // Four clocks per instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] NOP_ONE_WORD = 2'h1;
  localparam logic [1:0] NOP_TWO_WORD = 2'h2;

  // Register map, byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_BANK   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_COUNT  = 4'hC;
  localparam int         CTRL_EXEC_EN = 0;
  localparam int         CTRL_EXT_EN  = 1;
  localparam logic [1:0]       CTRL_RESET = 2'h1;
  localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_NOP
  } isnz_exec_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        next_two_word;
  } isnz_instr_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              indexed;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } isnz_mem_req_t;

  typedef struct packed {
    logic             exec_en;
    logic             ext_en;
    logic [BANK_W-1:0] bank_select_register;
  } isnz_cfg_t;

  typedef struct packed {
    logic        busy;
    logic        skip;
    logic [7:0]  result;
    logic [15:0] exec_count;
    logic [15:0] skip_count;
  } isnz_stat_t;

endpackage : isnz_pkg

//--- hdl/isnz_ahb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module isnz_ahb_regs (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Block side
  output isnz_pkg::isnz_cfg_t     cfg,
  input  wire isnz_pkg::isnz_stat_t stat
);
  import isnz_pkg::*;

  typedef struct packed {
    logic             exec_en;
    logic             ext_en;
    logic [BANK_W-1:0] bank;
    logic             pend_wr;
    logic             pend_rd;
    logic [3:0]       addr;
    logic [31:0]      rdata;
  } isnz_bus_state_t;

  isnz_bus_state_t r;
  isnz_bus_state_t next_r;
  logic [31:0]     sel_data;

  always_comb begin
    unique case (r.addr)
      REG_CTRL:   sel_data = {30'h0, r.ext_en, r.exec_en};
      REG_BANK:   sel_data = {28'h0, r.bank};
      REG_STATUS: sel_data = {22'h0, stat.busy, stat.skip, stat.result};
      REG_COUNT:  sel_data = {stat.skip_count, stat.exec_count};
      default:    sel_data = 32'h0;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.pend_wr = 1'b0;
    if (r.pend_wr) begin
      if (r.addr == REG_CTRL) begin
        next_r.exec_en = hwdata[CTRL_EXEC_EN];
        next_r.ext_en  = hwdata[CTRL_EXT_EN];
      end
      if (r.addr == REG_BANK) begin
        next_r.bank = hwdata[BANK_W-1:0];
      end
    end
    // Reads take one wait state so the data word comes from a flop
    if (r.pend_rd) begin
      next_r.pend_rd = 1'b0;
      next_r.rdata   = sel_data;
    end else if (hsel && htrans[1] && hready) begin
      next_r.addr    = haddr[3:0];
      next_r.pend_wr = hwrite;
      next_r.pend_rd = !hwrite;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '{exec_en: CTRL_RESET[CTRL_EXEC_EN], ext_en: CTRL_RESET[CTRL_EXT_EN],
             bank: BANK_RESET, pend_wr: 1'b0, pend_rd: 1'b0, addr: 4'h0, rdata: 32'h0};
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout = !r.pend_rd;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;
  assign cfg       = '{exec_en: r.exec_en, ext_en: r.ext_en, bank_select_register: r.bank};

endmodule : isnz_ahb_regs
`default_nettype wire

//--- hdl/isnz_exec.sv
// Functional notes
// - Recognise opcode 010010, then d bit, a bit and 8-bit file address.
// - Read the file byte and add one; status flags stay untouched.
// - d=0: result goes to the working register, file byte unchanged.
// - d=1: result is written back into the addressed file byte.
// - Nonzero result skips the next instruction; zero result does not.
// - On skip, drop the prefetched word and run one no-operation cycle.
// - Skipping a two-word instruction runs two no-operation cycles.
// - a=0: address lies in the access bank, bank register ignored.
// - a=1: bank register and file address together form the address.
// - Extended set, a=0, address at most 5Fh: indexed offset addressing.
// - Q1 decode, Q2 read, Q3 process, Q4 write destination.
`timescale 1ns/1ps
`default_nettype none
module isnz_exec (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // AHB-Lite register bus
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Fetched instruction
  input  wire isnz_pkg::isnz_instr_t instr,
  // Data memory path
  output isnz_pkg::isnz_mem_req_t    mem_req,
  input  wire logic [7:0]            mem_rdata,
  // Working register write
  output logic                       w_we,
  output logic [7:0]                 w_data,
  // Pipeline control
  output logic                       skip_flush,
  output logic                       nop_active,
  output logic [1:0]                 q_phase
);
  import isnz_pkg::*;

  typedef struct packed {
    isnz_exec_state_t st;
    logic [1:0]       q;
    logic [1:0]       nop_left;
    logic             dest_file;
    logic             two_word;
    logic [7:0]       result;
    logic             skip;
    isnz_mem_req_t    mem;
    logic             w_we;
    logic [7:0]       w_data;
    logic             flush;
    logic [15:0]      exec_count;
    logic [15:0]      skip_count;
  } isnz_core_t;

  isnz_core_t r;
  isnz_core_t next_r;
  isnz_cfg_t  cfg;
  isnz_stat_t stat;

  isnz_ahb_regs u_regs (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .cfg       (cfg),
    .stat      (stat)
  );

  // Decode of the word presented in Q1
  logic                 op_match;
  logic                 accept;
  logic                 f_dest;
  logic                 f_acc;
  logic [7:0]           f_addr;
  logic                 use_index;
  logic [ADDR_W-1:0]    eff_addr;
  logic [7:0]           inc_value;

  assign f_dest   = instr.word[DEST_BIT];
  assign f_acc    = instr.word[ACC_BIT];
  assign f_addr   = instr.word[7:0];
  assign op_match = instr.word[OPC_MSB:OPC_LSB] == OPC_INC_SKIP_NZ;
  assign accept   = instr.valid && op_match && cfg.exec_en
                    && r.st == ST_IDLE && r.q == PH_Q1;
  assign use_index = cfg.ext_en && !f_acc && f_addr <= INDEX_MAX;

  always_comb begin
    if (f_acc) begin
      eff_addr = {cfg.bank_select_register, f_addr};
    end else if (use_index) begin
      // Offset only; the core adds the index pointer
      eff_addr = {ACCESS_LOW_BANK, f_addr};
    end else if (f_addr < ACCESS_SPLIT) begin
      eff_addr = {ACCESS_LOW_BANK, f_addr};
    end else begin
      eff_addr = {ACCESS_HI_BANK, f_addr};
    end
  end

  // Plain 8-bit add; no carry or zero flag leaves this block
  assign inc_value = mem_rdata + 8'h01;

  always_comb begin
    next_r = r;
    next_r.q      = r.q + 2'h1;
    next_r.mem.rd = 1'b0;
    next_r.mem.wr = 1'b0;
    next_r.w_we   = 1'b0;
    next_r.flush  = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (accept) begin
          next_r.st          = ST_EXEC;
          next_r.dest_file   = f_dest;
          next_r.mem.rd      = 1'b1;
          next_r.mem.addr    = eff_addr;
          next_r.mem.indexed = use_index;
        end
      end
      ST_EXEC: begin
        if (r.q == PH_Q3) begin
          next_r.result   = inc_value;
          next_r.skip     = inc_value != 8'h00;
          next_r.flush    = inc_value != 8'h00;
          next_r.two_word = instr.next_two_word;
          next_r.mem.wr   = r.dest_file;
          next_r.mem.wdata = inc_value;
          next_r.w_we     = !r.dest_file;
          next_r.w_data   = inc_value;
        end
        if (r.q == PH_Q4) begin
          next_r.exec_count = r.exec_count + 16'h0001;
          if (r.skip) begin
            next_r.st         = ST_NOP;
            next_r.skip_count = r.skip_count + 16'h0001;
            next_r.nop_left   = r.two_word ? NOP_TWO_WORD : NOP_ONE_WORD;
          end else begin
            next_r.st = ST_IDLE;
          end
        end
      end
      ST_NOP: begin
        if (r.q == PH_Q4) begin
          next_r.nop_left = r.nop_left - 2'h1;
          if (r.nop_left == NOP_ONE_WORD) begin
            next_r.st = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: ST_IDLE, q: PH_Q1, nop_left: 2'h0, dest_file: 1'b0,
             two_word: 1'b0, result: 8'h00, skip: 1'b0,
             mem: '{rd: 1'b0, wr: 1'b0, indexed: 1'b0, addr: 12'h000, wdata: 8'h00},
             w_we: 1'b0, w_data: 8'h00, flush: 1'b0,
             exec_count: 16'h0000, skip_count: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  assign mem_req    = r.mem;
  assign w_we       = r.w_we;
  assign w_data     = r.w_data;
  assign skip_flush = r.flush;
  assign nop_active = r.st == ST_NOP;
  assign q_phase    = r.q;
  assign stat       = '{busy: r.st != ST_IDLE, skip: r.skip, result: r.result,
                        exec_count: r.exec_count, skip_count: r.skip_count};

  // Checks
  sequence s_decode;
    instr.valid && op_match && cfg.exec_en && r.st == ST_IDLE && r.q == PH_Q1;
  endsequence

  sequence s_rd_q2;
    mem_req.rd && r.q == PH_Q2;
  endsequence

  sequence s_wb_q4;
    (mem_req.wr || w_we) && r.q == PH_Q4;
  endsequence

  sequence s_nop_one;
    nop_active [*4] ##1 !nop_active;
  endsequence

  sequence s_nop_two;
    nop_active [*8] ##1 !nop_active;
  endsequence

  opcode_decode_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    instr.valid && r.st == ST_IDLE && r.q == PH_Q1 && cfg.exec_en
      && instr.word[15:10] != 6'b010010 |=> !mem_req.rd)
    else $error("Foreign opcode started a read");

  phase_order_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_decode |=> s_rd_q2 ##1 (!mem_req.rd && !mem_req.wr && !w_we) ##1 s_wb_q4)
    else $error("Decode read process write order broken");

  increment_value_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    r.st == ST_EXEC && r.q == PH_Q3 |=>
      r.result == $past(mem_rdata) + 8'h01 && w_data == r.result
        && mem_req.wdata == r.result)
    else $error("Result is not the read byte plus one");

  dest_working_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_decode ##0 !f_dest |=> ##2 (w_we && !mem_req.wr))
    else $error("d clear did not write the working register");

  dest_file_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_decode ##0 f_dest |=> ##2 (mem_req.wr && !w_we
      && mem_req.addr == $past(eff_addr, 3)))
    else $error("d set did not write back the file byte");

  skip_nonzero_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_wb_q4 |-> skip_flush == (r.result != 8'h00))
    else $error("Flush does not follow a nonzero result");

  skip_one_nop_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    skip_flush && !r.two_word |=> s_nop_one)
    else $error("Skip did not insert exactly one idle cycle");

  skip_two_nop_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    skip_flush && r.two_word |=> s_nop_two)
    else $error("Two-word skip did not insert two idle cycles");

  access_bank_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_decode ##0 !f_acc && !use_index |=> mem_req.addr[11:8]
      == (($past(f_addr) < 8'h60) ? 4'h0 : 4'hF))
    else $error("Access bank address wrong");

  banked_addr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_decode ##0 f_acc |=> mem_req.addr
      == {$past(cfg.bank_select_register), $past(f_addr)} && !mem_req.indexed)
    else $error("Banked address not formed from bank register");

  indexed_mode_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_decode |=> mem_req.indexed == ($past(cfg.ext_en) && !$past(f_acc)
      && $past(f_addr) <= 8'h5F))
    else $error("Indexed addressing chosen wrongly");

  flush_timing_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    skip_flush |-> s_wb_q4 ##1 (nop_active && r.q == PH_Q1))
    else $error("Flush not aligned with writeback");

endmodule : isnz_exec
`default_nettype wire

//--- tb/isnz_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module isnz_exec_tb_top;
  import isnz_pkg::*;

  logic          clk_sys   = 1'b0;
  logic          rstn      = 1'b0;
  logic          hsel      = 1'b0;
  logic [31:0]   haddr     = 32'h0;
  logic [1:0]    htrans    = 2'h0;
  logic          hwrite    = 1'b0;
  logic [2:0]    hsize     = 3'h2;
  logic [31:0]   hwdata    = 32'h0;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  isnz_instr_t   instr     = '0;
  isnz_mem_req_t mem_req;
  logic [7:0]    mem_rdata = 8'h00;
  logic          w_we;
  logic [7:0]    w_data;
  logic          skip_flush;
  logic          nop_active;
  logic [1:0]    q_phase;
  logic          rdy_s;
  logic [31:0]   rd_s;
  int            n_mismatch = 0;
  int            comparisons = 0;
  int            n_exec = 0;
  int            n_skip = 0;

  always #25 clk_sys = ~clk_sys;

  isnz_exec isnz_exec_inst (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr(instr),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .w_we(w_we), .w_data(w_data),
    .skip_flush(skip_flush), .nop_active(nop_active), .q_phase(q_phase)
  );

  // Bus values as the next rising edge will see them
  always @(negedge clk_sys) begin
    rdy_s = hreadyout;
    rd_s  = hrdata;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    hsel   <= 1'b1;
    haddr  <= {28'h0, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (rdy_s !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : 32'h0;
    k = 0;
    do begin @(posedge clk_sys); k++; end while (rdy_s !== 1'b1 && k < 20);
    rd = rd_s;
    if (k >= 20) n_mismatch++;
  endtask : bus

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, adr, 32'h0, v);
    chk(v, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  task automatic exec(input logic [15:0] w, input logic [7:0] rv, input logic two,
                      input logic acc, input logic [11:0] ea, input logic ei);
    logic [7:0] r;
    logic [11:0] a;
    logic ix;
    logic [7:0] wd;
    logic [7:0] wwd;
    logic skp;
    logic [1:0] qrd;
    int k, nrd, nwr, nwe, nfl, nnop, trd, twr, tfl;
    r = rv + 8'h01;
    skp = (r != 8'h00);
    nrd = 0; nwr = 0; nwe = 0; nfl = 0; nnop = 0; trd = 0; twr = 0; tfl = 0;
    mem_rdata <= rv;
    instr.next_two_word <= two;
    k = 0;
    do begin @(posedge clk_sys); #1; k++; end while (q_phase !== PH_Q4 && k < 8);
    @(posedge clk_sys);
    instr.valid <= 1'b1;
    instr.word  <= w;
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    for (k = 1; k <= 12; k++) begin
      #1;
      if (mem_req.rd === 1'b1) begin nrd++; trd = k; a = mem_req.addr; ix = mem_req.indexed; end
      if (mem_req.rd === 1'b1) qrd = q_phase;
      if (mem_req.wr === 1'b1) begin nwr++; twr = k; wd = mem_req.wdata; end
      if (w_we === 1'b1) begin nwe++; twr = k; wwd = w_data; end
      if (skip_flush === 1'b1) begin nfl++; tfl = k; end
      if (nop_active === 1'b1) nnop++;
      @(posedge clk_sys);
    end
    if (!acc) begin
      chk(nrd + nwr + nwe + nfl, 0);
    end else begin
      n_exec++;
      if (skp) n_skip++;
      chk(trd, 1);
      chk(qrd, PH_Q2);
      chk(a, ea);
      chk(ix, ei);
      chk(twr, 3);
      chk(nwr, w[DEST_BIT]);
      chk(nwe, !w[DEST_BIT]);
      chk(w[DEST_BIT] ? wd : wwd, r);
      chk(nfl, skp);
      if (skp) chk(tfl, 3);
      chk(nnop, skp ? (two ? 8 : 4) : 0);
    end
    $display("exec %h done", w);
  endtask : exec

  task automatic results;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    #(5000 * 50);
    n_mismatch++;
    results();
  end

  initial begin
    logic [31:0] v;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(REG_BANK, 32'h0);
    $display("reset values done");
    bus(1'b1, REG_BANK, 32'h5, v);
    rd_chk(REG_BANK, 32'h5);
    exec(16'h4B34, 8'h10, 1'b0, 1'b1, 12'h534, 1'b0);
    exec(16'h4880, 8'hFF, 1'b0, 1'b1, 12'hF80, 1'b0);
    exec(16'h4A20, 8'h7F, 1'b1, 1'b1, 12'h020, 1'b0);
    exec(16'h4C20, 8'h01, 1'b0, 1'b0, 12'h000, 1'b0);
    rd_chk(REG_STATUS, 32'h0000_0180);
    bus(1'b1, REG_CTRL, 32'h3, v);
    exec(16'h485F, 8'h41, 1'b0, 1'b1, 12'h05F, 1'b1);
    exec(16'h4A60, 8'hFF, 1'b0, 1'b1, 12'hF60, 1'b0);
    exec(16'h495F, 8'h02, 1'b1, 1'b1, 12'h55F, 1'b0);
    bus(1'b1, REG_CTRL, 32'h0, v);
    exec(16'h4B34, 8'h10, 1'b0, 1'b0, 12'h000, 1'b0);
    rd_chk(REG_COUNT, {n_skip[15:0], n_exec[15:0]});
    $display("register and execution tests done");
    results();
  end
endmodule : isnz_exec_tb_top
`default_nettype wire
